// [hw/has_host_port.sv]
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////
module has_host_port #(
    parameter int ADDR_W = has_pkg::ADDR_W,
    parameter int DATA_W = has_pkg::DATA_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // host pins
    input  wire has_pkg::has_pins_s pins,
    // read cycle events
    output var  logic               counter_latch,
    output var  logic               read_beat,
    output var  has_pkg::has_rdkind_e read_kind,
    output var  logic [ADDR_W-1:0]  read_addr,
    // write side
    output var  logic               wr_commit,
    output var  has_pkg::has_wr_s   wr_commit_word,
    output var  logic               tx_push,
    output var  logic [DATA_W-1:0]  tx_push_data,
    // delayed status updates
    output var  logic               tx_level_update,
    output var  logic               rx_info_update,
    output var  logic               tx_info_update,
    output var  logic               drop_update
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (ADDR_W != has_pkg::ADDR_W || DATA_W != has_pkg::DATA_W) begin : g_chk
        $error("has_host_port: widths must match the pin struct");
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_rx_data(input logic [ADDR_W-1:0] a, input logic fs);
        return fs || (a[ADDR_W-1:5] == has_pkg::RX_DATA_REGION);
    endfunction

    function automatic logic is_tx_data(input logic [ADDR_W-1:0] a, input logic fs);
        return !fs && (a[ADDR_W-1:5] == has_pkg::TX_DATA_REGION);
    endfunction

    // cycles until a written value shows, never past the host wait
    function automatic logic [has_pkg::CNT_W-1:0] settle_cycles(input logic [ADDR_W-1:0] a);
        logic [has_pkg::CNT_W-1:0] c;
        c = has_pkg::CTRL_CYC;
        unique case (a)
            has_pkg::IDENTITY_REVISION,
            has_pkg::PATTERN_TEST,
            has_pkg::RECEIVE_FIFO_INFO,
            has_pkg::RECEIVE_DROP_CNT:  c = has_pkg::IMMED_CYC;
            has_pkg::INTERRUPT_STATUS:  c = has_pkg::INT_CYC;
            has_pkg::IRQ_CONFIG,
            has_pkg::TRANSMIT_FIFO_INF,
            has_pkg::TIMER_COUNT:       c = has_pkg::INFO_CYC;
            has_pkg::POWER_MGMT_CTRL:   c = has_pkg::PWR_CYC;
            has_pkg::FREE_RUN_COUNTER:  c = has_pkg::FREERUN_CYC;
            default:                    c = has_pkg::CTRL_CYC;
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        has_pkg::has_phase_e                               phase;
        logic                                              counter_latch;
        logic                                              read_beat;
        has_pkg::has_rdkind_e                              read_kind;
        logic [ADDR_W-1:0]                                 read_addr;
        has_pkg::has_wr_s                                  wr_cap;
        logic                                              commit_pend;
        logic [has_pkg::CNT_W-1:0]                         commit_cnt;
        has_pkg::has_wr_s                                  commit_hold;
        logic                                              wr_commit;
        has_pkg::has_wr_s                                  commit_out;
        logic                                              tx_push;
        logic [DATA_W-1:0]                                 tx_push_data;
        logic [has_pkg::EVT_N-1:0]                         evt_run;
        logic [has_pkg::EVT_N-1:0][has_pkg::CNT_W-1:0]     evt_cnt;
        logic [has_pkg::EVT_N-1:0]                         evt_fire;
    } has_state_s;

    has_state_s                state_ff;
    has_state_s                nxt_state;
    logic                      rd_act;
    logic                      wr_act;
    logic                      wr_done;
    logic [has_pkg::EVT_N-1:0] evt_trig;

    assign rd_act = !pins.chip_select_low && !pins.read_strobe_low;
    assign wr_act = !pins.chip_select_low && !pins.write_strobe_low;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_state               = state_ff;
        nxt_state.counter_latch = 1'b0;
        nxt_state.read_beat     = 1'b0;
        nxt_state.wr_commit     = 1'b0;
        nxt_state.tx_push       = 1'b0;
        nxt_state.evt_fire      = '0;
        wr_done                 = 1'b0;
        evt_trig                = '0;

        unique case (state_ff.phase)
            has_pkg::HAS_IDLE: begin
                if (rd_act) begin
                    nxt_state.phase         = has_pkg::HAS_READ;
                    nxt_state.counter_latch = 1'b1;
                    nxt_state.read_beat     = 1'b1;
                    nxt_state.read_addr     = pins.addr;
                    nxt_state.read_kind     = pins.fifo_select ? has_pkg::HAS_RD_DIRECT
                                                               : has_pkg::HAS_RD_SINGLE;
                end else if (wr_act) begin
                    nxt_state.phase       = has_pkg::HAS_WRITE;
                    nxt_state.wr_cap.addr = pins.addr;
                    nxt_state.wr_cap.data = pins.data;
                end
            end
            has_pkg::HAS_READ: begin
                if (!rd_act) begin
                    nxt_state.phase = has_pkg::HAS_IDLE;
                    if (is_rx_data(state_ff.read_addr, state_ff.read_kind[1])
                        || state_ff.read_addr == has_pkg::RX_STATUS_FIFO) begin
                        evt_trig[has_pkg::EVT_RX_INFO] = 1'b1;
                    end
                    if (state_ff.read_addr == has_pkg::TX_STATUS_FIFO) begin
                        evt_trig[has_pkg::EVT_TX_INFO] = 1'b1;
                    end
                    if (state_ff.read_addr == has_pkg::RECEIVE_DROP_CNT) begin
                        evt_trig[has_pkg::EVT_DROP] = 1'b1;
                    end
                end else if (pins.addr != state_ff.read_addr) begin
                    nxt_state.read_beat    = 1'b1;
                    nxt_state.read_addr    = pins.addr;
                    nxt_state.read_kind    = state_ff.read_kind[1] ? has_pkg::HAS_RD_DIRECT_BURST
                                                                   : has_pkg::HAS_RD_BURST;
                end
            end
            has_pkg::HAS_WRITE: begin
                if (wr_act) begin
                    nxt_state.wr_cap.addr = pins.addr;
                    nxt_state.wr_cap.data = pins.data;
                end else begin
                    nxt_state.phase = has_pkg::HAS_IDLE;
                    if (is_tx_data(state_ff.wr_cap.addr, 1'b0)) begin
                        nxt_state.tx_push       = 1'b1;
                        nxt_state.tx_push_data  = state_ff.wr_cap.data;
                        evt_trig[has_pkg::EVT_TX_LEVEL] = 1'b1;
                    end else begin
                        wr_done = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state.phase = has_pkg::HAS_IDLE;
            end
        endcase

        // delayed register write, a newer write flushes the older one
        if (state_ff.commit_pend) begin
            if (state_ff.commit_cnt <= 1 || wr_done) begin
                nxt_state.wr_commit   = 1'b1;
                nxt_state.commit_out  = state_ff.commit_hold;
                nxt_state.commit_pend = 1'b0;
            end else begin
                nxt_state.commit_cnt = state_ff.commit_cnt - 1'b1;
            end
        end
        if (wr_done) begin
            nxt_state.commit_pend = 1'b1;
            nxt_state.commit_hold = state_ff.wr_cap;
            nxt_state.commit_cnt  = settle_cycles(state_ff.wr_cap.addr);
        end

        // update timers, a running timer covers a fresh trigger unless it is on its last count
        for (int i = 0; i < has_pkg::EVT_N; i++) begin
            if (state_ff.evt_run[i]) begin
                if (state_ff.evt_cnt[i] <= 1) begin
                    nxt_state.evt_fire[i] = 1'b1;
                    nxt_state.evt_run[i]  = 1'b0;
                end else begin
                    nxt_state.evt_cnt[i] = state_ff.evt_cnt[i] - 1'b1;
                end
            end
            if (evt_trig[i] && !(state_ff.evt_run[i] && state_ff.evt_cnt[i] > 1)) begin
                nxt_state.evt_run[i] = 1'b1;
                nxt_state.evt_cnt[i] = has_pkg::EVT_CYC[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff       <= '0;
            state_ff.phase <= has_pkg::HAS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign counter_latch   = state_ff.counter_latch;
    assign read_beat       = state_ff.read_beat;
    assign read_kind       = state_ff.read_kind;
    assign read_addr       = state_ff.read_addr;
    assign wr_commit       = state_ff.wr_commit;
    assign wr_commit_word  = state_ff.commit_out;
    assign tx_push         = state_ff.tx_push;
    assign tx_push_data    = state_ff.tx_push_data;
    assign tx_level_update = state_ff.evt_fire[has_pkg::EVT_TX_LEVEL];
    assign rx_info_update  = state_ff.evt_fire[has_pkg::EVT_RX_INFO];
    assign tx_info_update  = state_ff.evt_fire[has_pkg::EVT_TX_INFO];
    assign drop_update     = state_ff.evt_fire[has_pkg::EVT_DROP];

endmodule // has_host_port
`default_nettype wire

// [hw/has_pkg.sv]
`default_nettype none
package has_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_NS           = 8;
    localparam int CNT_W            = 6;
    localparam int WAIT_IMMED_NS    = 8;
    localparam int WAIT_CTRL_NS     = 45;
    localparam int WAIT_INT_NS      = 90;
    localparam int WAIT_INFO_NS     = 135;
    localparam int WAIT_FREERUN_NS  = 180;
    localparam int WAIT_PWR_NS      = 315;
    localparam int WAIT_DROP_NS     = 180;
    localparam int TX_LEVEL_NS      = 135;
    // all times round down
    localparam logic [CNT_W-1:0] IMMED_CYC   = CNT_W'(WAIT_IMMED_NS / CLK_NS);
    localparam logic [CNT_W-1:0] CTRL_CYC    = CNT_W'(WAIT_CTRL_NS / CLK_NS);
    localparam logic [CNT_W-1:0] INT_CYC     = CNT_W'(WAIT_INT_NS / CLK_NS);
    localparam logic [CNT_W-1:0] INFO_CYC    = CNT_W'(WAIT_INFO_NS / CLK_NS);
    localparam logic [CNT_W-1:0] FREERUN_CYC = CNT_W'(WAIT_FREERUN_NS / CLK_NS);
    localparam logic [CNT_W-1:0] PWR_CYC     = CNT_W'(WAIT_PWR_NS / CLK_NS);
    localparam logic [CNT_W-1:0] DROP_CYC    = CNT_W'(WAIT_DROP_NS / CLK_NS);
    localparam logic [CNT_W-1:0] TXLVL_CYC   = CNT_W'(TX_LEVEL_NS / CLK_NS);

    ////////////////////////////////////////////////////////////////////////////
    // address map, byte addresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [2:0]        RX_DATA_REGION    = 3'h0;
    localparam logic [2:0]        TX_DATA_REGION    = 3'h1;
    localparam logic [ADDR_W-1:0] RX_STATUS_FIFO    = 8'h40;
    localparam logic [ADDR_W-1:0] TX_STATUS_FIFO    = 8'h48;
    localparam logic [ADDR_W-1:0] IDENTITY_REVISION = 8'h50;
    localparam logic [ADDR_W-1:0] IRQ_CONFIG        = 8'h54;
    localparam logic [ADDR_W-1:0] INTERRUPT_STATUS  = 8'h58;
    localparam logic [ADDR_W-1:0] INTERRUPT_ENABLE  = 8'h5C;
    localparam logic [ADDR_W-1:0] PATTERN_TEST      = 8'h64;
    localparam logic [ADDR_W-1:0] FIFO_INTERRUPT    = 8'h68;
    localparam logic [ADDR_W-1:0] RECEIVE_CONFIG    = 8'h6C;
    localparam logic [ADDR_W-1:0] TRANSMIT_CONFIG   = 8'h70;
    localparam logic [ADDR_W-1:0] HARDWARE_CONFIG   = 8'h74;
    localparam logic [ADDR_W-1:0] RX_DATAPATH_CTRL  = 8'h78;
    localparam logic [ADDR_W-1:0] RECEIVE_FIFO_INFO = 8'h7C;
    localparam logic [ADDR_W-1:0] TRANSMIT_FIFO_INF = 8'h80;
    localparam logic [ADDR_W-1:0] POWER_MGMT_CTRL   = 8'h84;
    localparam logic [ADDR_W-1:0] GPIO_CONFIG       = 8'h88;
    localparam logic [ADDR_W-1:0] TIMER_CONFIG      = 8'h8C;
    localparam logic [ADDR_W-1:0] TIMER_COUNT       = 8'h90;
    localparam logic [ADDR_W-1:0] BYTE_LANE_SWAP    = 8'h98;
    localparam logic [ADDR_W-1:0] FREE_RUN_COUNTER  = 8'h9C;
    localparam logic [ADDR_W-1:0] RECEIVE_DROP_CNT  = 8'hA0;
    localparam logic [ADDR_W-1:0] MAC_IND_COMMAND   = 8'hA4;
    localparam logic [ADDR_W-1:0] MAC_IND_DATA      = 8'hA8;
    localparam logic [ADDR_W-1:0] FLOW_CTRL_CONFIG  = 8'hAC;
    localparam logic [ADDR_W-1:0] EEPROM_COMMAND    = 8'hB0;
    localparam logic [ADDR_W-1:0] EEPROM_DATA       = 8'hB4;

    ////////////////////////////////////////////////////////////////////////////
    // update event indices
    localparam int EVT_N        = 4;
    localparam int EVT_TX_LEVEL = 0;
    localparam int EVT_RX_INFO  = 1;
    localparam int EVT_TX_INFO  = 2;
    localparam int EVT_DROP     = 3;
    localparam logic [EVT_N-1:0][CNT_W-1:0] EVT_CYC = {DROP_CYC, INFO_CYC, INFO_CYC, TXLVL_CYC};

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        HAS_IDLE  = 3'b001,
        HAS_READ  = 3'b010,
        HAS_WRITE = 3'b100
    } has_phase_e;

    typedef enum logic [1:0] {
        HAS_RD_SINGLE       = 2'h0,
        HAS_RD_BURST        = 2'h1,
        HAS_RD_DIRECT       = 2'h2,
        HAS_RD_DIRECT_BURST = 2'h3
    } has_rdkind_e;

    typedef struct packed {
        logic              chip_select_low;
        logic              read_strobe_low;
        logic              write_strobe_low;
        logic              fifo_select;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } has_pins_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } has_wr_s;

endpackage
`default_nettype wire

// [test/has_host_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module has_host_port_chk (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst_b,
    // host pins
    input wire has_pkg::has_pins_s   pins,
    // outputs watched
    input wire logic                 counter_latch,
    input wire logic                 read_beat,
    input wire has_pkg::has_rdkind_e read_kind,
    input wire logic [7:0]           read_addr,
    input wire logic                 wr_commit,
    input wire has_pkg::has_wr_s     wr_commit_word,
    input wire logic                 tx_push,
    input wire logic [31:0]          tx_push_data,
    input wire logic                 tx_level_update,
    input wire logic                 rx_info_update,
    input wire logic                 tx_info_update,
    input wire logic                 drop_update
);
    wire logic       rd_act = !pins.chip_select_low && !pins.read_strobe_low;
    wire logic       wr_act = !pins.chip_select_low && !pins.write_strobe_low;
    wire logic [2:0] region = pins.addr[7:5];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    sequence rd_start_s; rd_act && !$past(rd_act) && !$past(wr_act); endsequence
    sequence rd_end_s; $past(rd_act) && !rd_act; endsequence
    sequence wr_end_s; $past(wr_act) && !wr_act && !$past(rd_act); endsequence
    ////////////////////////////////////////////////////////////////////////////
    latch_start_a: assert property (rd_start_s |=> counter_latch && read_beat
        && read_addr == $past(pins.addr)) else $error("read start not latched");
    latch_once_a: assert property (counter_latch |-> $past(rd_act) && !$past(rd_act, 2))
        else $error("latch without read start");
    start_kind_a: assert property (rd_start_s |=> read_kind == ($past(pins.fifo_select) ?
        has_pkg::HAS_RD_DIRECT : has_pkg::HAS_RD_SINGLE)) else $error("wrong read kind");
    burst_beat_a: assert property (rd_act && $past(rd_act) && pins.addr != $past(pins.addr)
        |=> read_beat && read_kind[0]) else $error("burst beat missed");
    tx_push_a: assert property (wr_end_s ##0 $past(region) == has_pkg::TX_DATA_REGION
        |=> tx_push && tx_push_data == $past(pins.data, 2)) else $error("tx push wrong");
    ctrl_commit_a: assert property (wr_end_s ##0 $past(pins.addr) == has_pkg::INTERRUPT_ENABLE
        |-> ##1 !wr_commit [*5] ##1 wr_commit) else $error("control commit timing");
    status_commit_a: assert property (wr_end_s ##0 $past(pins.addr) == has_pkg::INTERRUPT_STATUS
        |-> ##12 wr_commit) else $error("status commit timing");
    tx_level_a: assert property (wr_end_s ##0 $past(region) == has_pkg::TX_DATA_REGION
        |-> ##[1:17] tx_level_update) else $error("tx level late");
    rx_info_a: assert property (rd_end_s ##0 read_addr == has_pkg::RX_STATUS_FIFO
        |-> ##[1:17] rx_info_update) else $error("rx info late");
    tx_info_a: assert property (rd_end_s ##0 read_addr == has_pkg::TX_STATUS_FIFO
        |-> ##[1:17] tx_info_update) else $error("tx info late");
    drop_upd_a: assert property (rd_end_s ##0 read_addr == has_pkg::RECEIVE_DROP_CNT
        |-> ##[1:23] drop_update) else $error("drop update late");
endmodule // has_host_port_chk
bind has_host_port has_host_port_chk i_chk (.clk, .rst_b, .pins, .counter_latch, .read_beat,
    .read_kind, .read_addr, .wr_commit, .wr_commit_word, .tx_push, .tx_push_data,
    .tx_level_update, .rx_info_update, .tx_info_update, .drop_update);
`default_nettype wire

// [test/has_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module has_host_model (
    // clock
    input  wire logic               clk,
    // host pins
    output var  has_pkg::has_pins_s pins
);
    initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 32'h0};
    ////////////////////////////////////////////////////////////////////////////
    task automatic set_rd(input logic [7:0] a, input logic f);
        @(posedge clk);
        pins.chip_select_low <= 1'b0;
        pins.read_strobe_low <= 1'b0;
        pins.fifo_select     <= f;
        pins.addr            <= a;
    endtask
    task automatic beat(input logic [7:0] a);
        @(posedge clk);
        pins.addr <= a;
    endtask
    task automatic stop();
        @(posedge clk);
        pins.chip_select_low <= 1'b1;
        pins.read_strobe_low <= 1'b1;
        pins.fifo_select     <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        pins.chip_select_low  <= 1'b0;
        pins.write_strobe_low <= 1'b0;
        pins.addr             <= a;
        pins.data             <= d;
        repeat (4) @(posedge clk);
        pins.chip_select_low  <= 1'b1;
        pins.write_strobe_low <= 1'b1;
        pins.data             <= ~d; // released bus shows no stale word
    endtask
    // pattern-test reads of 40 ns, one every 56 ns, fill a wait
    task automatic dummy(input int n);
        repeat (n) begin
            set_rd(has_pkg::PATTERN_TEST, 1'b0);
            repeat (4) @(posedge clk);
            stop();
            @(posedge clk);
        end
    endtask
    // 320 ns idle covers every wait
    task automatic gap();
        repeat (40) @(posedge clk);
    endtask
endmodule // has_host_model
`default_nettype wire

// [test/has_host_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module has_host_port_bench;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    has_pkg::has_pins_s   pins;
    logic                 latch, beat, commit, push, lvl, rxi, txi, drp;
    has_pkg::has_rdkind_e kind;
    logic [7:0]           raddr;
    has_pkg::has_wr_s     word;
    logic [31:0]          pdata;
    int                   num_errors = 0;
    int                   n_compared = 0;
    int                   cyc = 0;
    always #4 clk = ~clk;
    has_host_model i_host (.clk(clk), .pins(pins));
    has_host_port i_dut (.clk(clk), .rst_b(rst_b), .pins(pins), .counter_latch(latch),
        .read_beat(beat), .read_kind(kind), .read_addr(raddr), .wr_commit(commit),
        .wr_commit_word(word), .tx_push(push), .tx_push_data(pdata), .tx_level_update(lvl),
        .rx_info_update(rxi), .tx_info_update(txi), .drop_update(drp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pulse selector for the cycle counter
    function automatic logic pick(input int w);
        case (w)
            0:       return commit;
            1:       return push;
            2:       return lvl;
            3:       return rxi;
            4:       return txi;
            default: return drp;
        endcase
    endfunction
    task automatic count_to(input int w, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (pick(w) !== 1'b1 && k < 60);
    endtask
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reads();
        for (int f = 0; f < 2; f++) begin
            i_host.set_rd(8'h08, f[0]);
            @(posedge clk);
            #1;
            chk("latch", 1, latch);
            chk("kind", {f[0], 1'b0}, kind);
            chk("addr", 8'h08, raddr);
            i_host.beat(8'h0C);
            @(posedge clk);
            #1;
            chk("beat", 1, beat);
            chk("burst kind", {f[0], 1'b1}, kind);
            chk("latch once", 0, latch);
            i_host.stop();
            i_host.gap();
        end
    endtask
    task automatic t_commit();
        logic [7:0] a [5];
        logic [5:0] n [5];
        int         k;
        a = '{has_pkg::INTERRUPT_ENABLE, has_pkg::INTERRUPT_STATUS, has_pkg::POWER_MGMT_CTRL,
              has_pkg::FREE_RUN_COUNTER, has_pkg::IDENTITY_REVISION};
        n = '{has_pkg::CTRL_CYC, has_pkg::INT_CYC, has_pkg::PWR_CYC, has_pkg::FREERUN_CYC,
              has_pkg::IMMED_CYC};
        foreach (a[i]) begin
            i_host.wr(a[i], {24'hC35A0F, a[i]});
            count_to(0, k);
            chk("commit delay", 40'(n[i]) + 1, 40'(k));
            chk("commit word", {a[i], 24'hC35A0F, a[i]}, word);
            i_host.gap();
        end
    endtask
    task automatic t_tx();
        int k;
        i_host.wr(8'h24, 32'h1234ABCD);
        count_to(1, k);
        chk("push delay", 1, 40'(k));
        chk("push data", 32'h1234ABCD, pdata);
        count_to(2, k);
        chk("level in time", 1, 40'(k <= 16));
        i_host.gap();
    endtask
    task automatic t_side(input logic [7:0] a, input int w, input int lim);
        int k;
        i_host.dummy(3);
        i_host.set_rd(a, 1'b0);
        i_host.stop();
        count_to(w, k);
        chk("update in time", 1, 40'(k <= lim));
        i_host.gap();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        i_host.gap();
        t_reads();
        t_commit();
        t_tx();
        t_side(has_pkg::RX_STATUS_FIFO, 3, 17);
        t_side(has_pkg::TX_STATUS_FIFO, 4, 17);
        t_side(has_pkg::RECEIVE_DROP_CNT, 5, 23);
        end_sim();
    end
endmodule // has_host_port_bench
`default_nettype wire
